// ===== hw/ccp_standard_pwm.sv
// Capture/compare/PWM unit with Avalon-MM registers and interrupt
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
module ccp_standard_pwm
	import pwm_pkg::*;
#(
	parameter bit SECOND_INSTANCE = 1'b0
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire avl_req_s    avl_req_i,
	output logic [31:0]      avl_readdata_o,
	output logic             avl_waitrequest_o,
	input  wire logic        sleep_i,
	input  wire logic        capture_pin_i,
	input  wire logic [15:0] timer1_count_i,
	input  wire logic        adc_enable_i,
	output logic             pulse_output_pin_o,
	output logic             pulse_output_oe_o,
	output logic             adc_trigger_o,
	output logic             timer1_reset_o,
	output logic             irq_o
);

	logic [7:0]  pwm_mode_control;
	logic [7:0]  duty_high_write;
	logic [7:0]  period_value;
	logic [2:0]  timer_ctrl;
	logic [15:0] capcmp;
	logic [1:0]  status;
	logic [1:0]  mask;
	logic [7:0]  next_pwm_mode_control;
	logic [7:0]  next_duty_high_write;
	logic [7:0]  next_period_value;
	logic [2:0]  next_timer_ctrl;
	logic [15:0] next_capcmp;
	logic [1:0]  next_status;
	logic [1:0]  next_mask;
	logic [31:0] next_readdata;
	logic        next_waitrequest;
	logic        next_irq;
	logic [31:0] read_mux;

	logic [7:0]  duty_active_buffer;
	logic [1:0]  duty_latch;
	logic        pin_level;
	logic        pin_oe;
	logic        cap_prev;
	logic [3:0]  cap_count;
	logic        match_prev;
	logic        adc_trigger;
	logic        t1_reset;
	logic [7:0]  next_duty_active_buffer;
	logic [1:0]  next_duty_latch;
	logic        next_pin_level;
	logic        next_pin_oe;
	logic        next_cap_prev;
	logic [3:0]  next_cap_count;
	logic        next_match_prev;
	logic        next_adc_trigger;
	logic        next_t1_reset;

	timebase_s   tb;
	logic [3:0]  unit_mode_select;
	unit_kind_e  kind;
	logic        unit_off;
	logic [9:0]  duty_new;
	logic        pwm_match;
	logic        rise;
	logic        fall;
	logic        cap_event;
	logic        match_event;
	logic        cmp_flag;
	logic        period_event;
	logic        bus_take;

	pwm_timebase u_timebase (
		.clk_sys_i  (clk_sys_i),
		.rst_n_i    (rst_n_i),
		.run_i      (!sleep_i && timer_ctrl[TCTRL_ON_BIT]),
		.prescale_i (timer_ctrl[1:0]),
		.period_i   (period_value),
		.tb_o       (tb)
	);

	assign unit_mode_select = pwm_mode_control[CTRL_MODE_HI:0];

	always_comb begin
		if (unit_mode_select[3:2] == MODE_PWM_TOP) begin
			kind = UNIT_PWM;
		end else if (unit_mode_select inside {MODE_CAP_FALL,
				MODE_CAP_RISE, MODE_CAP_4, MODE_CAP_16}) begin
			kind = UNIT_CAPTURE;
		end else if (unit_mode_select inside {MODE_CMP_TOGGLE,
				MODE_CMP_SET, MODE_CMP_CLEAR, MODE_CMP_SOFT,
				MODE_CMP_ADC}) begin
			kind = UNIT_COMPARE;
		end else begin
			kind = UNIT_IDLE;
		end
	end

	assign unit_off = (kind == UNIT_IDLE);
	// Low duty bits only used by pulse mode
	assign duty_new = {duty_high_write,
		pwm_mode_control[CTRL_DUTY_HI:CTRL_DUTY_LO]};
	// Never true when duty exceeds the period, so the pin stays high
	assign pwm_match = ({tb.count, tb.ext} ==
		{duty_active_buffer, duty_latch});
	assign rise = capture_pin_i && !cap_prev;
	assign fall = !capture_pin_i && cap_prev;
	assign period_event = (kind == UNIT_PWM) && tb.wrap;

	always_comb begin
		cap_event = 1'b0;
		if (kind == UNIT_CAPTURE && !sleep_i) begin
			unique case (unit_mode_select)
				MODE_CAP_FALL: cap_event = fall;
				MODE_CAP_RISE: cap_event = rise;
				MODE_CAP_4:    cap_event = rise &&
					(cap_count[1:0] == CAP4_LAST);
				default:       cap_event = rise &&
					(cap_count == CAP16_LAST);
			endcase
		end
	end

	assign match_event = (kind == UNIT_COMPARE) && !sleep_i &&
		(timer1_count_i == capcmp) && !match_prev;

	always_comb begin
		cmp_flag = 1'b0;
		if (match_event) begin
			unique case (unit_mode_select)
				MODE_CMP_SET:   cmp_flag = 1'b1;
				MODE_CMP_CLEAR: cmp_flag = 1'b1;
				MODE_CMP_SOFT:  cmp_flag = 1'b1;
				MODE_CMP_ADC:   cmp_flag = SECOND_INSTANCE;
				default:        cmp_flag = 1'b0;
			endcase
		end
	end

	// Core: pulse generator, capture prescaler and compare actions
	always_comb begin
		next_duty_active_buffer = duty_active_buffer;
		next_duty_latch         = duty_latch;
		next_pin_level          = pin_level;
		next_pin_oe             = pin_oe;
		next_cap_prev           = cap_prev;
		next_cap_count          = cap_count;
		next_match_prev         = match_prev;
		next_adc_trigger        = 1'b0;
		next_t1_reset           = 1'b0;
		if (!sleep_i) begin
			next_cap_prev   = capture_pin_i;
			next_match_prev = (timer1_count_i == capcmp);
			unique case (kind)
				UNIT_IDLE: begin
					next_duty_active_buffer = RST_DUTY;
					next_duty_latch         = 2'h0;
					next_pin_level          = 1'b0;
					next_pin_oe             = 1'b0;
					next_cap_count          = 4'h0;
				end
				UNIT_PWM: begin
					next_pin_oe = 1'b1;
					if (tb.wrap) begin
						next_duty_active_buffer = duty_new[9:2];
						next_duty_latch         = duty_new[1:0];
						next_pin_level          = (duty_new != 10'h000);
					end else if (pwm_match) begin
						next_pin_level = 1'b0;
					end
				end
				UNIT_CAPTURE: begin
					next_pin_oe = 1'b0;
					if (rise) begin
						next_cap_count = cap_count + 4'h1;
					end
				end
				UNIT_COMPARE: begin
					next_pin_oe = (unit_mode_select != MODE_CMP_SOFT) &&
						(unit_mode_select != MODE_CMP_ADC);
					if (match_event) begin
						unique case (unit_mode_select)
							MODE_CMP_SET:    next_pin_level = 1'b1;
							MODE_CMP_CLEAR:  next_pin_level = 1'b0;
							MODE_CMP_TOGGLE: next_pin_level = !pin_level;
							MODE_CMP_ADC: begin
								next_adc_trigger = adc_enable_i;
								next_t1_reset    = 1'b1;
							end
							default: next_pin_level = pin_level;
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			duty_active_buffer <= RST_DUTY;
			duty_latch         <= 2'h0;
			pin_level          <= 1'b0;
			pin_oe             <= 1'b0;
			cap_prev           <= 1'b0;
			cap_count          <= 4'h0;
			match_prev         <= 1'b0;
			adc_trigger        <= 1'b0;
			t1_reset           <= 1'b0;
		end else begin
			duty_active_buffer <= next_duty_active_buffer;
			duty_latch         <= next_duty_latch;
			pin_level          <= next_pin_level;
			pin_oe             <= next_pin_oe;
			cap_prev           <= next_cap_prev;
			cap_count          <= next_cap_count;
			match_prev         <= next_match_prev;
			adc_trigger        <= next_adc_trigger;
			t1_reset           <= next_t1_reset;
		end
	end

	assign pulse_output_pin_o = pin_level;
	assign pulse_output_oe_o  = pin_oe;
	assign adc_trigger_o      = adc_trigger;
	assign timer1_reset_o     = t1_reset;

	always_comb begin
		unique case (avl_req_i.address)
			OFS_CONTROL:     read_mux = {24'h0, pwm_mode_control};
			OFS_DUTY_HIGH:   read_mux = {24'h0, duty_high_write};
			OFS_DUTY_ACTIVE: read_mux = {24'h0, duty_active_buffer};
			OFS_PERIOD:      read_mux = {24'h0, period_value};
			OFS_TIMER_CTRL:  read_mux = {29'h0, timer_ctrl};
			OFS_TIMER_COUNT: read_mux = {24'h0, tb.count};
			OFS_CAPCMP:      read_mux = {16'h0, capcmp};
			OFS_STATUS:      read_mux = {30'h0, status};
			OFS_MASK:        read_mux = {30'h0, mask};
			default:         read_mux = 32'h0;
		endcase
	end

	// One wait cycle per access; write lands on the waitrequest-low edge
	assign bus_take = avl_req_i.write && !avl_waitrequest_o;

	always_comb begin
		next_pwm_mode_control = pwm_mode_control;
		next_duty_high_write  = duty_high_write;
		next_period_value     = period_value;
		next_timer_ctrl       = timer_ctrl;
		next_capcmp           = capcmp;
		next_mask             = mask;
		next_status           = status;
		next_readdata         = avl_readdata_o;
		next_waitrequest      = 1'b1;
		if ((avl_req_i.read || avl_req_i.write) && avl_waitrequest_o) begin
			next_waitrequest = 1'b0;
			next_readdata    = avl_req_i.read ? read_mux : 32'h0;
		end
		if (bus_take) begin
			unique case (avl_req_i.address)
				OFS_CONTROL: next_pwm_mode_control =
					{2'h0, avl_req_i.writedata[CTRL_WIDTH-1:0]};
				OFS_DUTY_HIGH: next_duty_high_write =
					avl_req_i.writedata[7:0];
				OFS_PERIOD: next_period_value = avl_req_i.writedata[7:0];
				OFS_TIMER_CTRL: next_timer_ctrl =
					avl_req_i.writedata[TCTRL_WIDTH-1:0];
				OFS_CAPCMP: next_capcmp = avl_req_i.writedata[15:0];
				OFS_STATUS: next_status =
					status & ~avl_req_i.writedata[STAT_WIDTH-1:0];
				OFS_MASK: next_mask = avl_req_i.writedata[STAT_WIDTH-1:0];
				default: next_mask = mask;
			endcase
		end
		// Hardware events win over a clear or write in the same cycle
		if (cap_event) begin
			next_capcmp = timer1_count_i;
		end
		next_status[STAT_EVENT]  = next_status[STAT_EVENT] ||
			cap_event || cmp_flag;
		next_status[STAT_PERIOD] = next_status[STAT_PERIOD] || period_event;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pwm_mode_control  <= RST_CONTROL;
			duty_high_write   <= RST_DUTY;
			period_value      <= RST_PERIOD;
			timer_ctrl        <= RST_TIMER_CTRL;
			capcmp            <= RST_CAPCMP;
			status            <= RST_STATUS;
			mask              <= RST_MASK;
			avl_readdata_o    <= 32'h0;
			avl_waitrequest_o <= 1'b1;
			irq_o             <= 1'b0;
		end else begin
			pwm_mode_control  <= next_pwm_mode_control;
			duty_high_write   <= next_duty_high_write;
			period_value      <= next_period_value;
			timer_ctrl        <= next_timer_ctrl;
			capcmp            <= next_capcmp;
			status            <= next_status;
			mask              <= next_mask;
			avl_readdata_o    <= next_readdata;
			avl_waitrequest_o <= next_waitrequest;
			irq_o             <= next_irq;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_period_start;
		kind == UNIT_PWM && !sleep_i && tb.wrap;
	endsequence

	property p_active_copy;
		s_period_start |=> {duty_active_buffer, duty_latch} ==
			$past(duty_new);
	endproperty
	a_active_copy: assert property (p_active_copy)
		else $error("duty not copied into active buffer at period end");

	property p_mid_hold;
		kind == UNIT_PWM && !tb.wrap |=> $stable(duty_active_buffer);
	endproperty
	a_mid_hold: assert property (p_mid_hold)
		else $error("active duty changed inside a period");

	property p_period_set;
		s_period_start |=> pulse_output_pin_o == ($past(duty_new) != 10'h000);
	endproperty
	a_period_set: assert property (p_period_set)
		else $error("pin not set at period start");

	property p_match_clear;
		kind == UNIT_PWM && !sleep_i && !tb.wrap && pwm_match
			|=> !pulse_output_pin_o;
	endproperty
	a_match_clear: assert property (p_match_clear)
		else $error("pin not cleared on duty match");

	property p_sleep_freeze;
		sleep_i |=> $stable(pulse_output_pin_o) &&
			$stable(duty_active_buffer) && !adc_trigger_o;
	endproperty
	a_sleep_freeze: assert property (p_sleep_freeze)
		else $error("unit state moved while asleep");

	property p_off_release;
		unit_off && !sleep_i |=> !pulse_output_oe_o && !pulse_output_pin_o;
	endproperty
	a_off_release: assert property (p_off_release)
		else $error("off or reserved mode still drives the pin");

	property p_capture;
		cap_event |=> capcmp == $past(timer1_count_i) && status[STAT_EVENT];
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture did not store timer value and flag");

	property p_cmp_set;
		unit_mode_select == MODE_CMP_SET && match_event
			|=> pulse_output_pin_o && status[STAT_EVENT];
	endproperty
	a_cmp_set: assert property (p_cmp_set)
		else $error("compare set did not drive pin high with flag");

	property p_soft_only;
		unit_mode_select == MODE_CMP_SOFT && !sleep_i |=> !pulse_output_oe_o;
	endproperty
	a_soft_only: assert property (p_soft_only)
		else $error("software interrupt mode drives the pin");

	property p_adc_trigger;
		unit_mode_select == MODE_CMP_ADC && match_event
			|=> adc_trigger_o == $past(adc_enable_i) && timer1_reset_o
			##1 !adc_trigger_o && !timer1_reset_o;
	endproperty
	a_adc_trigger: assert property (p_adc_trigger)
		else $error("conversion trigger pulse wrong");

	property p_reset;
		disable iff (1'b0)
		!rst_n_i |=> pwm_mode_control == RST_CONTROL && !pulse_output_oe_o
			&& duty_active_buffer == RST_DUTY && !irq_o;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset did not restore defaults");

	property p_bus_ack;
		(avl_req_i.read || avl_req_i.write) && avl_waitrequest_o
			|=> !avl_waitrequest_o ##1 avl_waitrequest_o;
	endproperty
	a_bus_ack: assert property (p_bus_ack)
		else $error("bus access not acknowledged after one wait cycle");

endmodule // ccp_standard_pwm

// ===== hw/pwm_pkg.sv
// Constants, field layouts and carrier types of the capture/compare/PWM unit
package pwm_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [5:0] OFS_CONTROL      = 6'h00;
	localparam logic [5:0] OFS_DUTY_HIGH    = 6'h04;
	localparam logic [5:0] OFS_DUTY_ACTIVE  = 6'h08;
	localparam logic [5:0] OFS_PERIOD       = 6'h0c;
	localparam logic [5:0] OFS_TIMER_CTRL   = 6'h10;
	localparam logic [5:0] OFS_TIMER_COUNT  = 6'h14;
	localparam logic [5:0] OFS_CAPCMP       = 6'h18;
	localparam logic [5:0] OFS_STATUS       = 6'h1c;
	localparam logic [5:0] OFS_MASK         = 6'h20;

	// Field positions
	localparam int CTRL_DUTY_HI   = 5;
	localparam int CTRL_DUTY_LO   = 4;
	localparam int CTRL_MODE_HI   = 3;
	localparam int CTRL_WIDTH     = 6;
	localparam int TCTRL_ON_BIT   = 2;
	localparam int TCTRL_WIDTH    = 3;
	localparam int STAT_EVENT     = 0;
	localparam int STAT_PERIOD    = 1;
	localparam int STAT_WIDTH     = 2;

	// Reset values
	localparam logic [7:0]  RST_CONTROL    = 8'h00;
	localparam logic [7:0]  RST_DUTY       = 8'h00;
	localparam logic [7:0]  RST_PERIOD     = 8'h00;
	localparam logic [2:0]  RST_TIMER_CTRL = 3'h0;
	localparam logic [15:0] RST_CAPCMP     = 16'h0000;
	localparam logic [1:0]  RST_STATUS     = 2'h0;
	localparam logic [1:0]  RST_MASK       = 2'h0;

	// Mode select codes
	localparam logic [3:0] MODE_OFF        = 4'h0;
	localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
	localparam logic [3:0] MODE_CAP_4      = 4'h6;
	localparam logic [3:0] MODE_CAP_16     = 4'h7;
	localparam logic [3:0] MODE_CMP_SET    = 4'h8;
	localparam logic [3:0] MODE_CMP_CLEAR  = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT   = 4'ha;
	localparam logic [3:0] MODE_CMP_ADC    = 4'hb;
	localparam logic [1:0] MODE_PWM_TOP    = 2'h3;

	// Prescale select codes and timing counts
	localparam logic [1:0] PRESCALE_1   = 2'h0;
	localparam logic [1:0] PRESCALE_4   = 2'h1;
	localparam logic [1:0] PHASE_LAST   = 2'h3;
	localparam logic [1:0] PRE4_LAST    = 2'h3;
	localparam logic [3:0] PRE16_LAST   = 4'hf;
	localparam logic [1:0] CAP4_LAST    = 2'h3;
	localparam logic [3:0] CAP16_LAST   = 4'hf;

	typedef enum logic [1:0] {
		UNIT_IDLE,
		UNIT_CAPTURE,
		UNIT_COMPARE,
		UNIT_PWM
	} unit_kind_e;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [5:0]  address;
		logic [31:0] writedata;
	} avl_req_s;

	typedef struct packed {
		logic [7:0] count;
		logic [1:0] ext;
		logic       wrap;
	} timebase_s;

endpackage

// ===== hw/pwm_timebase.sv
// Period timer with prescaler and clock phase forming the 10-bit time base
`timescale 1ns/1ns
module pwm_timebase
	import pwm_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic       run_i,
	input  wire logic [1:0] prescale_i,
	input  wire logic [7:0] period_i,
	output timebase_s       tb_o
);

	logic [1:0] phase;
	logic [3:0] pre;
	logic [7:0] count;
	logic [1:0] next_phase;
	logic [3:0] next_pre;
	logic [7:0] next_count;
	logic       inc;
	logic       wrap;

	always_comb begin
		next_phase = phase;
		next_pre   = pre;
		next_count = count;
		inc        = 1'b0;
		wrap       = 1'b0;
		if (run_i) begin
			next_phase = phase + 2'h1;
			if (phase == PHASE_LAST) begin
				next_pre = pre + 4'h1;
				unique case (prescale_i)
					PRESCALE_1: inc = 1'b1;
					PRESCALE_4: inc = (pre[1:0] == PRE4_LAST);
					default:    inc = (pre == PRE16_LAST);
				endcase
			end
			if (inc) begin
				if (count == period_i) begin
					next_count = 8'h00;
					wrap       = 1'b1;
				end else begin
					next_count = count + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			phase <= 2'h0;
			pre   <= 4'h0;
			count <= 8'h00;
		end else begin
			phase <= next_phase;
			pre   <= next_pre;
			count <= next_count;
		end
	end

	always_comb begin
		tb_o.count = count;
		tb_o.wrap  = wrap;
		unique case (prescale_i)
			PRESCALE_1: tb_o.ext = phase;
			PRESCALE_4: tb_o.ext = pre[1:0];
			default:    tb_o.ext = pre[3:2];
		endcase
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_ext_phase;
		prescale_i == PRESCALE_1 |-> tb_o.ext == phase;
	endproperty
	a_ext_phase: assert property (p_ext_phase)
		else $error("extension bits not from clock phase at 1:1");

	property p_count_step;
		inc && !wrap |=> count == $past(count) + 8'h01;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("period timer did not step by one");

	property p_wrap_zero;
		wrap |=> count == 8'h00 && !wrap;
	endproperty
	a_wrap_zero: assert property (p_wrap_zero)
		else $error("period timer not cleared after period match");

	property p_hold;
		!run_i |=> $stable(count) && $stable(phase) && $stable(pre);
	endproperty
	a_hold: assert property (p_hold)
		else $error("period timer moved while halted");

endmodule // pwm_timebase

// ===== bench/pwm_far_side.sv
// Far-side model: external 16-bit timer, capture source and pin load
`timescale 1ns/1ns
module pwm_far_side (
	input  wire logic   clk_sys_i,
	input  wire logic   rst_n_i,
	input  wire logic   pin_i,
	input  wire logic   oe_i,
	output logic [15:0] timer1_count_o,
	output logic        capture_pin_o,
	output logic        pin_level_o
);
	logic [5:0] count;
	// Short wrap so a compare match recurs every 64 clocks
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			count <= 6'h00;
		else
			count <= count + 6'h01;
	end
	assign timer1_count_o = {10'h000, count};
	// One rising edge every 16 clocks
	assign capture_pin_o = count[3];
	// Pull-down holds the line low while released
	assign pin_level_o = oe_i ? pin_i : 1'b0;
endmodule // pwm_far_side

// ===== bench/tb_ccp_standard_pwm.sv
// Self-checking testbench of the capture/compare/PWM unit
`timescale 1ns/1ns
module tb_ccp_standard_pwm import pwm_pkg::*;;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	avl_req_s    req       = '0;
	logic        sleep     = 1'b0;
	logic        adc_en    = 1'b1;
	logic [31:0] rdata, q;
	logic [15:0] t1_count;
	logic        wait_req, cap_pin, pin, oe, adc_trg, t1_rst, irq, level;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          hi, n_adc;
	logic [5:0]  ofs [8] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14,
		6'h1c, 6'h20};
	logic [3:0]  cmp [5] = '{4'h8, 4'h9, 4'ha, 4'h2, 4'hb};
	logic [4:0]  e_oe = 5'b01011, e_pin = 5'b00001, e_fl = 5'b00111;

	always #10 clk_sys_i = ~clk_sys_i;

	ccp_standard_pwm DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.avl_req_i(req), .avl_readdata_o(rdata),
		.avl_waitrequest_o(wait_req), .sleep_i(sleep),
		.capture_pin_i(cap_pin), .timer1_count_i(t1_count),
		.adc_enable_i(adc_en), .pulse_output_pin_o(pin),
		.pulse_output_oe_o(oe), .adc_trigger_o(adc_trg),
		.timer1_reset_o(t1_rst), .irq_o(irq));

	pwm_far_side far (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.pin_i(pin), .oe_i(oe), .timer1_count_o(t1_count),
		.capture_pin_o(cap_pin), .pin_level_o(level));

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic bus(input logic rd, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		req <= '{rd, !rd, a, d};
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wait_req !== 1'b0 && n < 50);
		q = rdata;
		req <= '0;
		if (n >= 50)
			chk("waitrequest", 32'h0, 32'h1);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b0, a, d);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		bus(1'b1, a, 32'h0);
		chk("register", e, q);
	endtask

	task automatic pause(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	initial begin
		pause(20);
		rst_n_i <= 1'b1;
		foreach (ofs[i]) rd(ofs[i], 32'h0);
		wr(OFS_DUTY_ACTIVE, 32'hff);
		wr(6'h24, 32'hff);
		rd(OFS_DUTY_ACTIVE, 32'h0);
		rd(6'h24, 32'h0);
		chk("oe", 32'h0, 32'(oe));
		$display("test reset done");
		for (int p = 0; p < 2; p++) begin
			wr(OFS_TIMER_CTRL, 32'(4 + p));
			for (int d = 0; d < 6; d++) begin
				wr(OFS_DUTY_HIGH, 32'(d >> 2));
				wr(OFS_CONTROL, 32'(12 + ((d & 3) << 4)));
				pause(32 << (2 * p));
				hi = 0;
				repeat (40 << (2 * p)) begin
					@(posedge clk_sys_i);
					hi += int'(level);
				end
				// Pin clears the clock after the match: one clock over d steps
				chk("high", 32'(10 * ((d == 0) ? 0 : (d > 3) ?
					(4 << (2 * p)) : ((d << (2 * p)) + 1))),
					32'(hi));
			end
		end
		rd(OFS_DUTY_ACTIVE, 32'h1);
		$display("test duty done");
		wr(OFS_PERIOD, 32'hff);
		wr(OFS_DUTY_HIGH, 32'h80);
		rd(OFS_DUTY_ACTIVE, 32'h1);
		sleep <= 1'b1;
		bus(1'b1, OFS_TIMER_COUNT, 32'h0);
		hi = int'(q);
		pause(40);
		rd(OFS_TIMER_COUNT, 32'(hi));
		sleep <= 1'b0;
		pause(4200);
		rd(OFS_DUTY_ACTIVE, 32'h80);
		wr(OFS_MASK, 32'h2);
		pause(2);
		chk("irq", 32'h1, 32'(irq));
		wr(OFS_MASK, 32'h0);
		wr(OFS_STATUS, 32'h3);
		rd(OFS_STATUS, 32'h0);
		chk("irq", 32'h0, 32'(irq));
		$display("test sleep and irq done");
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CONTROL, 32'(c ? 2 * c - 1 : 0));
			pause(2);
			chk("oe", 32'h0, 32'(oe));
			chk("pin", 32'h0, 32'(pin));
		end
		for (int c = 4; c < 8; c++) begin
			wr(OFS_CONTROL, 32'(c));
			wr(OFS_STATUS, 32'h3);
			pause(300);
			bus(1'b1, OFS_STATUS, 32'h0);
			chk("capture flag", 32'h1, 32'(q[0]));
		end
		$display("test capture done");
		foreach (cmp[i]) begin
			wr(OFS_CONTROL, 32'(cmp[i]));
			wr(OFS_CAPCMP, 32'h10);
			wr(OFS_STATUS, 32'h3);
			n_adc = 0;
			hi = int'(level);
			repeat (64) begin
				@(posedge clk_sys_i);
				n_adc += int'(adc_trg) + int'(t1_rst);
			end
			chk("oe", 32'(e_oe[i]), 32'(oe));
			chk("pin", 32'((i == 3) ? (hi == 0) : e_pin[i]),
				32'(level));
			chk("triggers", 32'((i == 4) ? 2 : 0), 32'(n_adc));
			bus(1'b1, OFS_STATUS, 32'h0);
			chk("event flag", 32'(e_fl[i]), 32'(q[0]));
		end
		adc_en <= 1'b0;
		pause(2);
		n_adc = 0;
		repeat (64) begin
			@(posedge clk_sys_i);
			n_adc += 2 * int'(adc_trg) + int'(t1_rst);
		end
		chk("disabled trigger", 32'h1, 32'(n_adc));
		$display("test compare done");
		rst_n_i <= 1'b0;
		pause(20);
		rst_n_i <= 1'b1;
		rd(OFS_CAPCMP, 32'h0);
		chk("oe", 32'h0, 32'(oe));
		$display("test second reset done");
		tally_and_finish();
	end

	initial begin
		pause(40000);
		n_mismatch++;
		tally_and_finish();
	end
endmodule // tb_ccp_standard_pwm
